// [sasl_core.v]
// Stack-based arithmetic and square-root execution datapath.
// Assumes instructions and analog inputs come from logic on I_CLK_SYS;
// only the variant strap is a pin and is synchronised here.
`timescale 1ns/1ps
`include "sasl_defs.vh"

// Contract
// - Add, subtract, multiply, divide second by top
// - Plain root replaces top with its root
// - Low-cut roots: input second, threshold top
// - Pass variants output input when not above
// - Zero variant outputs zero when not above
// - Threshold accepted from zero to maximum
// - Indexed low-cut roots have instances one-three
// - Wide variant numbers steps twenty to fiftynine; code numbers from one after reset until an interval start
// - Wide variant constants twenty-sixtythree, alias prefix rejected
// - Load pushes; binary ops consume second entry
// - Store copies top; steps ascend in order
// - Four stack, four buffer, I/O, constants
module sasl_core (
    input wire I_CLK_SYS,
    input wire I_RST_N,
    input wire I_FRONT_PANEL_VARIANT,
    input wire I_INTERVAL_START,
    input wire I_OP_VALID,
    input wire [3:0] I_OP_CODE,
    input wire [2:0] I_OP_INDEX,
    input wire [5:0] I_OP_ADDR,
    input wire [31:0] I_ANALOG_IN_1,
    input wire [31:0] I_ANALOG_IN_2,
    input wire [31:0] I_ANALOG_IN_3,
    input wire I_CONST_WE,
    input wire [5:0] I_CONST_ADDR,
    input wire [31:0] I_CONST_DATA,
    output reg O_READY,
    output reg O_DONE,
    output wire [31:0] O_STACK_TOP,
    output wire [31:0] O_STACK_SECOND,
    output reg [31:0] O_ANALOG_OUT_1,
    output reg [31:0] O_ANALOG_OUT_2,
    output reg [5:0] O_STEP_NUMBER,
    output reg [3:0] O_FAULT
);

////////////////////////////////////////////////////////////////////////////////
// Storage
reg [31:0] s1, s2, s3, s4; // Arithmetic stack, s1 is the top
reg [31:0] tbuf [1:4]; // Buffer registers
reg [31:0] cmem [0:63]; // Fixed constants, indexed by printed number
reg [6:0] used; // Dynamic instances run this interval
reg strap_m, strap_s; // Variant strap synchroniser
reg wide_variant; // Strap caught while reset is held
reg [1:0] state; // Sequencer state
reg [4:0] iter; // Remaining serial iterations
reg [25:0] rem; // Partial remainder
reg [24:0] acc; // Quotient or root bits
reg [47:0] rad; // Radicand bits still to feed
reg [23:0] divisor; // Divisor mantissa
reg res_sign; // Sign of the serial result
reg [9:0] res_exp; // Biased exponent of the serial result

assign O_STACK_TOP = s1;
assign O_STACK_SECOND = s2;

////////////////////////////////////////////////////////////////////////////////
// Floating-point helpers (truncating, denormals read as zero)

// Mantissa with hidden bit, zero for a zero exponent
function [23:0] fmant;
    input [31:0] x;
    begin
        fmant = (x[30:23] == 8'h00) ? 24'h000000 : {1'b1, x[22:0]};
    end
endfunction

// Pack with saturation to the largest magnitude and flush to zero
function [31:0] fpack;
    input sg;
    input [9:0] ex;
    input [23:0] mt;
    begin
        if (!mt[23] || ex[9] || ex == 10'h000)
            fpack = `SASL_FLT_ZERO;
        else if (ex > `SASL_EXP_MAX)
            fpack = {sg, `SASL_FLT_MAG};
        else
            fpack = {sg, ex[7:0], mt[22:0]};
    end
endfunction

// Ordered key so that an unsigned compare orders floats
function [31:0] fkey;
    input [31:0] x;
    begin
        if (x[30:23] == 8'h00)
            fkey = 32'h80000000;
        else if (x[31])
            fkey = ~x;
        else
            fkey = {1'b1, x[30:0]};
    end
endfunction

// Sum of two floats; subtraction flips the second sign first
function [31:0] fadd;
    input [31:0] a;
    input [31:0] b;
    reg [31:0] p, q;
    reg [7:0] d;
    reg [26:0] al;
    reg [27:0] sum;
    reg [9:0] ex;
    integer i;
    begin
        if (a[30:0] < b[30:0])
        begin
            p = b;
            q = a;
        end
        else
        begin
            p = a;
            q = b;
        end
        d = p[30:23] - q[30:23];
        ex = {2'b00, p[30:23]};
        al = (d > 8'h1a) ? 27'h0000000 : ({fmant(q), 3'h0} >> d);
        if (p[31] == q[31])
            sum = {1'b0, fmant(p), 3'h0} + {1'b0, al};
        else
            sum = {1'b0, fmant(p), 3'h0} - {1'b0, al};
        // Carry out: renormalise right by one
        if (sum[27])
        begin
            sum = sum >> 1;
            ex = ex + 10'h001;
        end
        // Cancellation: renormalise left
        for (i = 0; i < 27; i = i + 1)
        begin
            if (!sum[26] && sum != 28'h0000000)
            begin
                sum = sum << 1;
                ex = ex - 10'h001;
            end
        end
        fadd = fpack(p[31], ex, sum[26:3]);
    end
endfunction

// Product of two floats
function [31:0] fmul;
    input [31:0] a;
    input [31:0] b;
    reg [47:0] pr;
    reg [9:0] ex;
    begin
        pr = fmant(a) * fmant(b);
        ex = {2'b00, a[30:23]} + {2'b00, b[30:23]} - `SASL_EXP_BIAS;
        if (pr[47])
            fmul = fpack(a[31] ^ b[31], ex + 10'h001, pr[47:24]);
        else
            fmul = fpack(a[31] ^ b[31], ex, pr[46:23]);
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Instruction decode: operand fetch, faults and immediate results
reg accept; // Instruction taken this cycle
reg is_load; // Pushes a value
reg [31:0] ld_val; // Value to push
reg addr_bad; // Register or constant number out of range
reg [2:0] dyn_bit; // Dynamic instance slot
reg is_dyn; // Low-cut root instruction
reg is_root; // Any root instruction
reg [31:0] root_in; // Root input
reg cut; // Input not above the low-cut point
reg [3:0] set_f; // Faults raised this cycle
reg [9:0] ue; // Unbiased exponent of the root input

// Combinational decode of the offered instruction
always @*
begin
    accept = O_READY && I_OP_VALID;
    is_load = 1'b0;
    ld_val = `SASL_FLT_ZERO;
    addr_bad = 1'b0;
    is_dyn = (I_OP_CODE == `SASL_OP_SQT) || (I_OP_CODE == `SASL_OP_SQA)
        || (I_OP_CODE == `SASL_OP_SQB);
    is_root = is_dyn || (I_OP_CODE == `SASL_OP_SQR);
    dyn_bit = 3'h0;
    case (I_OP_CODE)
        `SASL_OP_LDX:
        begin
            is_load = 1'b1;
            ld_val = (I_OP_INDEX == 3'h1) ? I_ANALOG_IN_1 :
                (I_OP_INDEX == 3'h2) ? I_ANALOG_IN_2 : I_ANALOG_IN_3;
            addr_bad = (I_OP_INDEX == 3'h0) || (I_OP_INDEX > 3'h3);
        end
        `SASL_OP_LDY:
        begin
            is_load = 1'b1;
            ld_val = (I_OP_INDEX == 3'h1) ? O_ANALOG_OUT_1 : O_ANALOG_OUT_2;
            addr_bad = (I_OP_INDEX == 3'h0) || (I_OP_INDEX > 3'h2);
        end
        `SASL_OP_LDC, `SASL_OP_LDH:
        begin
            // Alias prefix names the same constant on the standard variant
            is_load = 1'b1;
            ld_val = cmem[I_OP_ADDR];
            addr_bad = wide_variant ? ((I_OP_CODE == `SASL_OP_LDH)
                || I_OP_ADDR < `SASL_CONST_LO_WIDE)
                : (I_OP_ADDR < `SASL_CONST_LO_STD || I_OP_ADDR > `SASL_CONST_HI_STD);
        end
        `SASL_OP_LDT, `SASL_OP_STT:
        begin
            is_load = (I_OP_CODE == `SASL_OP_LDT);
            ld_val = tbuf[(I_OP_INDEX == 3'h0) ? 3'h1 : I_OP_INDEX[2:0]];
            addr_bad = (I_OP_INDEX == 3'h0) || (I_OP_INDEX > 3'h4);
        end
        `SASL_OP_STY:
            addr_bad = (I_OP_INDEX == 3'h0) || (I_OP_INDEX > 3'h2);
        `SASL_OP_SQA:
        begin
            dyn_bit = I_OP_INDEX;
            addr_bad = (I_OP_INDEX == 3'h0) || (I_OP_INDEX > 3'h3);
        end
        `SASL_OP_SQB:
        begin
            dyn_bit = I_OP_INDEX + 3'h3;
            addr_bad = (I_OP_INDEX == 3'h0) || (I_OP_INDEX > 3'h3);
        end
        default:
            addr_bad = 1'b0;
    endcase
    // Low-cut roots read the input below the threshold
    root_in = is_dyn ? s2 : s1;
    // Any threshold from zero to the largest magnitude compares exactly
    cut = is_dyn && (fkey(s2) <= fkey(s1));
    ue = {2'b00, root_in[30:23]} - `SASL_EXP_BIAS;
    set_f = 4'h0;
    if (accept)
    begin
        set_f[`SASL_F_ADDR] = addr_bad || (O_STEP_NUMBER > `SASL_STEP_LAST);
        set_f[`SASL_F_DIV0] = (I_OP_CODE == `SASL_OP_DIV) && s1[30:23] == 8'h00;
        set_f[`SASL_F_NEGROOT] = is_root && !cut && root_in[31]
            && root_in[30:23] != 8'h00;
        // A second use of an instance in one interval is flagged
        set_f[`SASL_F_REUSE] = is_dyn && !addr_bad && used[dyn_bit];
    end
end

////////////////////////////////////////////////////////////////////////////////
// Variant strap: two flops, caught while reset is held
always @(posedge I_CLK_SYS)
begin
    strap_m <= I_FRONT_PANEL_VARIANT;
    strap_s <= strap_m;
    if (!I_RST_N)
        wide_variant <= strap_s;
end

// Constant area writes from the parameter port, out-of-range numbers dropped
always @(posedge I_CLK_SYS)
begin
    if (I_CONST_WE && (wide_variant ? I_CONST_ADDR >= `SASL_CONST_LO_WIDE
        : (I_CONST_ADDR >= `SASL_CONST_LO_STD && I_CONST_ADDR <= `SASL_CONST_HI_STD)))
        cmem[I_CONST_ADDR] <= I_CONST_DATA;
end

////////////////////////////////////////////////////////////////////////////////
// Sequencer, stack and output registers
always @(posedge I_CLK_SYS)
begin
    if (!I_RST_N)
    begin
        s1 <= `SASL_FLT_ZERO;
        s2 <= `SASL_FLT_ZERO;
        s3 <= `SASL_FLT_ZERO;
        s4 <= `SASL_FLT_ZERO;
        tbuf[1] <= `SASL_FLT_ZERO;
        tbuf[2] <= `SASL_FLT_ZERO;
        tbuf[3] <= `SASL_FLT_ZERO;
        tbuf[4] <= `SASL_FLT_ZERO;
        used <= 7'h00;
        state <= `SASL_ST_IDLE;
        iter <= 5'h00;
        rem <= 26'h0000000;
        acc <= 25'h0000000;
        rad <= 48'h000000000000;
        divisor <= 24'h000000;
        res_sign <= 1'b0;
        res_exp <= 10'h000;
        O_READY <= 1'b1;
        O_DONE <= 1'b0;
        O_ANALOG_OUT_1 <= `SASL_FLT_ZERO;
        O_ANALOG_OUT_2 <= `SASL_FLT_ZERO;
        O_STEP_NUMBER <= `SASL_STEP_FIRST_STD;
        O_FAULT <= 4'h0;
    end
    else
    begin
        O_DONE <= 1'b0;
        // Set wins over the interval clear
        O_FAULT <= (I_INTERVAL_START ? 4'h0 : O_FAULT) | set_f;
        if (I_INTERVAL_START)
        begin
            // New interval restarts numbering and frees dynamic instances
            O_STEP_NUMBER <= wide_variant ? `SASL_STEP_FIRST_WIDE
                : `SASL_STEP_FIRST_STD;
            used <= 7'h00;
        end
        else if (accept && O_STEP_NUMBER <= `SASL_STEP_LAST)
            O_STEP_NUMBER <= O_STEP_NUMBER + 6'h01;
        if (accept && is_dyn && !addr_bad)
            used[dyn_bit] <= 1'b1;
        case (state)
            `SASL_ST_IDLE:
            begin
                if (accept && addr_bad)
                    O_DONE <= 1'b1; // Bad number: no stack change
                else if (accept)
                begin
                    O_DONE <= 1'b1;
                    // Binary and low-cut ops consume the second entry
                    if (I_OP_CODE >= `SASL_OP_ADD && I_OP_CODE != `SASL_OP_SQR)
                    begin
                        s2 <= s3;
                        s3 <= s4;
                        s4 <= `SASL_FLT_ZERO;
                    end
                    if (is_load)
                    begin
                        s1 <= ld_val;
                        s2 <= s1;
                        s3 <= s2;
                        s4 <= s3;
                    end
                    case (I_OP_CODE)
                        `SASL_OP_STY:
                            if (I_OP_INDEX == 3'h1)
                                O_ANALOG_OUT_1 <= s1;
                            else
                                O_ANALOG_OUT_2 <= s1;
                        `SASL_OP_STT:
                            tbuf[I_OP_INDEX] <= s1;
                        `SASL_OP_ADD:
                            s1 <= fadd(s2, s1);
                        `SASL_OP_SUB:
                            s1 <= fadd(s2, {~s1[31], s1[30:0]});
                        `SASL_OP_MLT:
                            s1 <= fmul(s2, s1);
                        `SASL_OP_DIV:
                        begin
                            // Divide by zero saturates with the exclusive-or of both signs
                            if (s1[30:23] == 8'h00)
                                s1 <= fpack(s2[31] ^ s1[31], 10'h0ff, 24'h800000);
                            else if (s2[30:23] == 8'h00)
                                s1 <= `SASL_FLT_ZERO;
                            else
                            begin
                                // Serial restoring divide, one bit a cycle
                                O_DONE <= 1'b0;
                                O_READY <= 1'b0;
                                state <= `SASL_ST_DIV;
                                rem <= {2'b00, fmant(s2)};
                                divisor <= fmant(s1);
                                acc <= 25'h0000000;
                                res_sign <= s2[31] ^ s1[31];
                                res_exp <= {2'b00, s2[30:23]} - {2'b00, s1[30:23]}
                                    + `SASL_EXP_DIV;
                                iter <= `SASL_DIV_ITER;
                            end
                        end
                        `SASL_OP_SQR, `SASL_OP_SQT, `SASL_OP_SQA, `SASL_OP_SQB:
                        begin
                            if (cut)
                                s1 <= (I_OP_CODE == `SASL_OP_SQB) ? `SASL_FLT_ZERO
                                    : s2;
                            else if (root_in[31] || root_in[30:23] == 8'h00)
                                s1 <= `SASL_FLT_ZERO;
                            else
                            begin
                                // Serial root, two radicand bits a cycle
                                O_DONE <= 1'b0;
                                O_READY <= 1'b0;
                                state <= `SASL_ST_ROOT;
                                rem <= 26'h0000000;
                                acc <= 25'h0000000;
                                rad <= ue[0] ? {fmant(root_in), 24'h000000}
                                    : {1'b0, fmant(root_in), 23'h000000};
                                res_sign <= 1'b0;
                                res_exp <= {ue[9], ue[9:1]} + `SASL_EXP_BIAS;
                                iter <= `SASL_ROOT_ITER;
                            end
                        end
                        default:
                            s1 <= is_load ? ld_val : s1;
                    endcase
                end
            end
            `SASL_ST_DIV:
            begin
                if (iter == 5'h00)
                begin
                    s1 <= acc[24] ? fpack(res_sign, res_exp + 10'h001, acc[24:1])
                        : fpack(res_sign, res_exp, acc[23:0]);
                    state <= `SASL_ST_IDLE;
                    O_READY <= 1'b1;
                    O_DONE <= 1'b1;
                end
                else
                begin
                    iter <= iter - 5'h01;
                    acc <= {acc[23:0], (rem >= {2'b00, divisor})};
                    rem <= ((rem >= {2'b00, divisor}) ? rem - {2'b00, divisor} : rem) << 1;
                end
            end
            `SASL_ST_ROOT:
            begin
                if (iter == 5'h00)
                begin
                    s1 <= fpack(1'b0, res_exp, acc[23:0]);
                    state <= `SASL_ST_IDLE;
                    O_READY <= 1'b1;
                    O_DONE <= 1'b1;
                end
                else
                begin
                    iter <= iter - 5'h01;
                    rad <= rad << 2;
                    if ({rem[23:0], rad[47:46]} >= {acc[23:0], 2'b01})
                    begin
                        rem <= {rem[23:0], rad[47:46]} - {acc[23:0], 2'b01};
                        acc <= {acc[23:0], 1'b1};
                    end
                    else
                    begin
                        rem <= {rem[23:0], rad[47:46]};
                        acc <= {acc[23:0], 1'b0};
                    end
                end
            end
            default:
            begin
                state <= `SASL_ST_IDLE;
                O_READY <= 1'b1;
            end
        endcase
    end
end

endmodule // sasl_core

// [sasl_core_chk.sv]
// Checker for the stack arithmetic and low-cut root datapath ports.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
`include "sasl_defs.vh"
module sasl_core_chk (
    input wire I_CLK_SYS,
    input wire I_RST_N,
    input wire I_INTERVAL_START,
    input wire I_OP_VALID,
    input wire [3:0] I_OP_CODE,
    input wire [2:0] I_OP_INDEX,
    input wire [31:0] I_ANALOG_IN_1,
    input wire O_READY,
    input wire O_DONE,
    input wire [31:0] O_STACK_TOP,
    input wire [31:0] O_STACK_SECOND,
    input wire [31:0] O_ANALOG_OUT_1,
    input wire [5:0] O_STEP_NUMBER,
    input wire [3:0] O_FAULT
);
    ////////////////////////////////////////////////////////////////
    // Accept strobe and operand class
    wire take = O_READY && I_OP_VALID;
    // Normal operands only, so the serial counts are the plain ones
    wire top_norm = (O_STACK_TOP[30:23] != 8'h00) && (O_STACK_TOP[30:23] != 8'hff);
    wire sec_norm = (O_STACK_SECOND[30:23] != 8'h00) && (O_STACK_SECOND[30:23] != 8'hff);
    default clocking cb @(posedge I_CLK_SYS);
    endclocking
    default disable iff (!I_RST_N);
    ////////////////////////////////////////////////////////////////
    fast_done_a:
    assert property (take && I_OP_CODE < `SASL_OP_DIV |=> O_DONE)
        else $error("short instruction gave no done");
    load_push_a:
    assert property (take && I_OP_CODE == `SASL_OP_LDX && I_OP_INDEX == 3'h1
        |=> O_STACK_TOP == $past(I_ANALOG_IN_1) && O_STACK_SECOND == $past(O_STACK_TOP))
        else $error("load did not push");
    store_copy_a:
    assert property (take && I_OP_CODE == `SASL_OP_STY && I_OP_INDEX == 3'h1
        |=> O_ANALOG_OUT_1 == $past(O_STACK_TOP) && $stable(O_STACK_TOP))
        else $error("store did not copy top");
    step_advance_a:
    assert property (take && !I_INTERVAL_START && O_STEP_NUMBER < 6'h3c
        |=> O_STEP_NUMBER == $past(O_STEP_NUMBER) + 6'h01)
        else $error("step number did not advance");
    div_latency_a:
    assert property (take && I_OP_CODE == `SASL_OP_DIV && top_norm && sec_norm |-> ##27 O_DONE)
        else $error("divide done late or early");
    root_serial_a:
    assert property (take && I_OP_CODE == `SASL_OP_SQR && !O_STACK_TOP[31] && top_norm
        |=> (!O_READY && !O_DONE)[*8] ##18 O_DONE)
        else $error("root timing wrong");
    lowcut_zero_a:
    assert property (take && I_OP_CODE == `SASL_OP_SQB && !O_STACK_TOP[31] && !O_STACK_SECOND[31]
        && O_STACK_SECOND[30:0] <= O_STACK_TOP[30:0]
        |-> ##[1:26] (O_DONE && O_STACK_TOP == 32'h00000000))
        else $error("low-cut zero variant not zero");
    div_zero_flag_a:
    assert property (take && I_OP_CODE == `SASL_OP_DIV && O_STACK_TOP[30:0] == 31'h00000000
        |-> ##[1:27] O_FAULT[`SASL_F_DIV0])
        else $error("divide by zero not flagged");
endmodule // sasl_core_chk

bind sasl_core sasl_core_chk sasl_core_chk_inst (
    .I_CLK_SYS(I_CLK_SYS), .I_RST_N(I_RST_N), .I_INTERVAL_START(I_INTERVAL_START),
    .I_OP_VALID(I_OP_VALID), .I_OP_CODE(I_OP_CODE), .I_OP_INDEX(I_OP_INDEX),
    .I_ANALOG_IN_1(I_ANALOG_IN_1), .O_READY(O_READY), .O_DONE(O_DONE),
    .O_STACK_TOP(O_STACK_TOP), .O_STACK_SECOND(O_STACK_SECOND),
    .O_ANALOG_OUT_1(O_ANALOG_OUT_1), .O_STEP_NUMBER(O_STEP_NUMBER), .O_FAULT(O_FAULT)
);

// [sasl_defs.vh]
// Shared constants for the stack arithmetic and square-root datapath.
// Assumes inclusion by bare name from the datapath module file.
`ifndef SASL_DEFS_VH
`define SASL_DEFS_VH

// Instruction codes
`define SASL_OP_NOP 4'h0
`define SASL_OP_LDX 4'h1
`define SASL_OP_LDY 4'h2
`define SASL_OP_LDC 4'h3
`define SASL_OP_LDH 4'h4
`define SASL_OP_LDT 4'h5
`define SASL_OP_STY 4'h6
`define SASL_OP_STT 4'h7
`define SASL_OP_ADD 4'h8
`define SASL_OP_SUB 4'h9
`define SASL_OP_MLT 4'ha
`define SASL_OP_DIV 4'hb
`define SASL_OP_SQR 4'hc
`define SASL_OP_SQT 4'hd
`define SASL_OP_SQA 4'he
`define SASL_OP_SQB 4'hf

// Sequencer states
`define SASL_ST_IDLE 2'h0
`define SASL_ST_DIV 2'h1
`define SASL_ST_ROOT 2'h2

// Single-precision values and exponent handling
`define SASL_FLT_ZERO 32'h00000000
`define SASL_FLT_MAG 31'h7f7fffff
`define SASL_EXP_BIAS 10'h07f
`define SASL_EXP_DIV 10'h07e
`define SASL_EXP_MAX 10'h0fe

// Iteration counts of the serial divider and root extractor
`define SASL_DIV_ITER 5'h19
`define SASL_ROOT_ITER 5'h18

// Program step numbering per variant
`define SASL_STEP_FIRST_STD 6'h01
`define SASL_STEP_FIRST_WIDE 6'h14
`define SASL_STEP_LAST 6'h3b

// Fixed constant number ranges per variant
`define SASL_CONST_LO_STD 6'h01
`define SASL_CONST_HI_STD 6'h3b
`define SASL_CONST_LO_WIDE 6'h14
`define SASL_CONST_HI_WIDE 6'h3f

// Fault flag positions
`define SASL_F_DIV0 0
`define SASL_F_NEGROOT 1
`define SASL_F_REUSE 2
`define SASL_F_ADDR 3

`endif

// [sasl_io_model.sv]
// Model of the signal input registers that feed the datapath.
// Assumes the bench loads values only between instructions.
`timescale 1ns/1ps
module sasl_io_model (
    input wire i_clk,
    input wire i_we,
    input wire [1:0] i_sel,
    input wire [31:0] i_val,
    output reg [31:0] o_in_1,
    output reg [31:0] o_in_2,
    output reg [31:0] o_in_3
);
    // Inputs start at zero so nothing unknown reaches a load
    initial
    begin
        o_in_1 = 32'h00000000;
        o_in_2 = 32'h00000000;
        o_in_3 = 32'h00000000;
    end
    // Register update; values hold until rewritten
    always @(posedge i_clk)
    begin
        if (i_we && i_sel == 2'h1) o_in_1 <= i_val;
        if (i_we && i_sel == 2'h2) o_in_2 <= i_val;
        if (i_we && i_sel == 2'h3) o_in_3 <= i_val;
    end
endmodule // sasl_io_model

// [stack_arith_sqrt_lowcut_unit_tb.sv]
// Self-checking bench for the stack arithmetic and low-cut root datapath.
// Assumes the checker binds itself to the datapath.
`timescale 1ns/1ps
`include "sasl_defs.vh"
module stack_arith_sqrt_lowcut_unit_tb;
    localparam [31:0] F3 = 32'h40400000, F4 = 32'h40800000, F5 = 32'h40a00000;
    localparam [31:0] F9 = 32'h41100000, F16 = 32'h41800000;
    reg clk, rst_n = 1'b0, variant = 1'b0, start = 1'b0, valid = 1'b0;
    reg [3:0] code = 4'h0;
    reg [2:0] idx = 3'h0;
    reg [5:0] addr = 6'h00, caddr = 6'h00;
    reg cwe = 1'b0, mwe = 1'b0;
    reg [1:0] msel = 2'h0;
    reg [31:0] cdata = 32'h0, mval = 32'h0, r;
    wire [31:0] in1, in2, in3, top, out1, out2;
    wire ready, done;
    wire [5:0] step;
    wire [3:0] fault;
    integer fails = 0, checks_done = 0, nacc = 0, cyc = 0, n, k, seed = 13;
    reg [31:0] q[$];
    // Expectation tables; low-cut codes are d/e/f as in the shared header
    reg [31:0] ae [0:3] = '{32'h41500000, 32'h40a00000, 32'h42100000, 32'h40100000};
    reg [31:0] cv [0:4] = '{32'h0, F4, F9, 32'h0, F16};
    reg [3:0] lc [0:5] = '{4'hd, 4'he, 4'he, 4'hf, 4'hf, 4'he};
    reg [2:0] li [0:5] = '{3'h0, 3'h1, 3'h2, 3'h1, 3'h2, 3'h3};
    reg [5:0] la [0:5] = '{6'h01, 6'h02, 6'h03, 6'h02, 6'h01, 6'h04};
    reg [31:0] le [0:5] = '{F3, F9, F3, 32'h0, F3, F9};
    ////////////////////////////////////////////////////////////////
    sasl_core sasl_core_inst (
        .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_FRONT_PANEL_VARIANT(variant),
        .I_INTERVAL_START(start), .I_OP_VALID(valid), .I_OP_CODE(code),
        .I_OP_INDEX(idx), .I_OP_ADDR(addr), .I_ANALOG_IN_1(in1),
        .I_ANALOG_IN_2(in2), .I_ANALOG_IN_3(in3), .I_CONST_WE(cwe),
        .I_CONST_ADDR(caddr), .I_CONST_DATA(cdata), .O_READY(ready), .O_DONE(done),
        .O_STACK_TOP(top), .O_STACK_SECOND(), .O_ANALOG_OUT_1(out1),
        .O_ANALOG_OUT_2(out2), .O_STEP_NUMBER(step), .O_FAULT(fault)
    );
    sasl_io_model sasl_io_model_inst (
        .i_clk(clk), .i_we(mwe), .i_sel(msel), .i_val(mval),
        .o_in_1(in1), .o_in_2(in2), .o_in_3(in3)
    );
    // 10 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////
    task check(input [31:0] seen, input [31:0] exp);
    begin
        checks_done = checks_done + 1;
        if (seen !== exp)
        begin
            fails = fails + 1;
            $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
        end
    end
    endtask
    task end_sim;
    begin
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    end
    endtask
    // Offer one instruction and note its result; valid stays up for chaining
    task op(input [3:0] c, input [2:0] i, input [5:0] a, input [31:0] e);
    begin
        q.push_back(e);
        @(negedge clk);
        valid = 1'b1;
        code = c;
        idx = i;
        addr = a;
        n = 0;
        while (ready !== 1'b1 && n < 100)
        begin
            @(negedge clk);
            n = n + 1;
        end
        @(posedge clk);
        nacc = nacc + 1;
    end
    endtask
    // Stop offering and wait until every noted result was seen
    task drain;
    begin
        @(negedge clk);
        valid = 1'b0;
        n = 0;
        while (q.size() > 0 && n < 100)
        begin
            @(negedge clk);
            n = n + 1;
        end
        if (q.size() > 0) fails = fails + 1;
    end
    endtask
    task cw(input [5:0] a, input [31:0] d);
    begin
        @(negedge clk);
        cwe = 1'b1;
        caddr = a;
        cdata = d;
        @(negedge clk);
        cwe = 1'b0;
    end
    endtask
    task setx(input [1:0] s, input [31:0] v);
    begin
        @(negedge clk);
        mwe = 1'b1;
        msel = s;
        mval = v;
        @(negedge clk);
        mwe = 1'b0;
    end
    endtask
    task begin_interval;
    begin
        @(negedge clk);
        start = 1'b1;
        @(negedge clk);
        start = 1'b0;
        nacc = 0;
    end
    endtask
    // Strap is caught only while reset is held
    task reset_to(input v);
    begin
        rst_n = 1'b0;
        variant = v;
        repeat (4) @(negedge clk);
        rst_n = 1'b1;
    end
    endtask
    ////////////////////////////////////////////////////////////////
    // Result watcher and cycle ceiling
    always @(negedge clk)
    begin
        cyc = cyc + 1;
        if (cyc > 20000)
        begin
            fails = fails + 1;
            end_sim;
        end
        else if (done === 1'b1 && q.size() > 0)
            check(top, q.pop_front());
        else if (done === 1'b1)
            check({31'h0, done}, 32'h0);
    end
    ////////////////////////////////////////////////////////////////
    initial
    begin
        reset_to(1'b0);
        check({26'h0, step}, 32'h1);
        for (k = 1; k < 5; k = k + 1)
            cw(k[5:0], cv[k]);
        setx(2'h1, F9);
        for (k = 0; k < 4; k = k + 1)
        begin
            op(`SASL_OP_LDX, 3'h1, 6'h00, F9);
            op(`SASL_OP_LDC, 3'h0, 6'h01, F4);
            op(`SASL_OP_ADD + k[3:0], 3'h0, 6'h00, ae[k]);
        end
        op(`SASL_OP_LDC, 3'h0, 6'h04, F16);
        op(`SASL_OP_SQR, 3'h0, 6'h00, F4);
        drain;
        check({26'h0, step}, nacc + 1);
        begin_interval;
        // Each dynamic instance but zero-variant instance three once in this interval
        for (k = 0; k < 6; k = k + 1)
        begin
            op(`SASL_OP_LDX, 3'h1, 6'h00, F9);
            op(`SASL_OP_LDC, 3'h0, la[k], cv[la[k]]);
            op(lc[k], li[k], 6'h00, le[k]);
        end
        op(`SASL_OP_STY, 3'h1, 6'h00, F9);
        op(`SASL_OP_STY, 3'h2, 6'h00, F9);
        drain;
        check(out1, F9);
        check(out2, F9);
        check({28'h0, fault}, 32'h0);
        op(`SASL_OP_LDX, 3'h1, 6'h00, F9);
        op(`SASL_OP_LDC, 3'h0, 6'h01, F4);
        op(`SASL_OP_SQT, 3'h0, 6'h00, F3);
        op(`SASL_OP_LDX, 3'h1, 6'h00, F9);
        op(`SASL_OP_LDC, 3'h0, 6'h03, 32'h0);
        op(`SASL_OP_DIV, 3'h0, 6'h00, 32'h7f7fffff);
        drain;
        for (k = 0; k < 3; k = k + 1)
        begin
            r = $random(seed);
            setx(2'h2, {9'h100, r[22:0]});
            op(`SASL_OP_LDX, 3'h2, 6'h00, {9'h100, r[22:0]});
            drain;
        end
        check({28'h0, fault}, 32'h5);
        check({26'h0, step}, nacc + 1);
        reset_to(1'b1);
        begin_interval;
        check({26'h0, step}, 32'h14);
        cw(6'h14, F5);
        op(`SASL_OP_LDC, 3'h0, 6'h14, F5);
        op(`SASL_OP_LDC, 3'h0, 6'h01, F5);
        drain;
        check({28'h0, fault}, 32'h8);
        end_sim;
    end
endmodule // stack_arith_sqrt_lowcut_unit_tb
